// >>> mmu_fault_pkg.sv
package mmu_fault_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0]  ADDR_SEG0 = 8'h00;
  localparam logic [7:0]  ADDR_CTRL = 8'h40;
  localparam logic [7:0]  ADDR_FSS  = 8'h44;
  localparam logic [7:0]  ADDR_DFC  = 8'h48;
  localparam logic [7:0]  ADDR_FIA  = 8'h4c;
  localparam logic [7:0]  ADDR_DFA  = 8'h50;
  localparam logic [7:0]  ADDR_STAT = 8'h54;
  localparam int          SEG_COUNT = 16;
  // machine_state_reg / control fields
  localparam int          CTL_FETCH_XLATE = 0;
  localparam int          CTL_DATA_XLATE  = 1;
  localparam int          CTL_BYTE_REV    = 2;
  localparam int          CTL_PROBLEM     = 3;
  localparam int          CTL_EXT_EN      = 4;
  localparam int          CTL_FLUSH       = 5;
  localparam logic [31:0] CTRL_RESET      = 32'h0;
  // segment_descriptor_reg fields
  localparam int          SEG_T_BIT  = 31;
  localparam int          SEG_KS_BIT = 30;
  localparam int          SEG_KP_BIT = 29;
  localparam int          SEG_N_BIT  = 28;
  localparam int          VSID_W     = 24;
  localparam int          VPN_W      = 40;
  localparam int          RPN_W      = 20;
  // cause bits, msb-0 bit n sits at position 31-n
  localparam int          CAUSE_PAGE   = 30;
  localparam int          CAUSE_NOEXEC = 28;
  localparam int          CAUSE_PROT   = 27;
  localparam int          CAUSE_DSTORE = 26;
  localparam int          CAUSE_EXTDIS = 20;
  // page attribute layout {w,i,g,pp[1:0]}
  localparam int          ATTR_W = 4;
  localparam int          ATTR_I = 3;
  localparam int          ATTR_G = 2;
  // access operation codes
  localparam logic [3:0]  OP_LOAD = 4'h0;
  localparam logic [3:0]  OP_STORE = 4'h1;
  localparam logic [3:0]  OP_FP_LOAD = 4'h2;
  localparam logic [3:0]  OP_FP_STORE = 4'h3;
  localparam logic [3:0]  OP_MULTI_LOAD = 4'h4;
  localparam logic [3:0]  OP_MULTI_STORE = 4'h5;
  localparam logic [3:0]  OP_STRING_LOAD = 4'h6;
  localparam logic [3:0]  OP_STRING_STORE = 4'h7;
  localparam logic [3:0]  OP_RESV_LOAD = 4'h8;
  localparam logic [3:0]  OP_COND_STORE = 4'h9;
  localparam logic [3:0]  OP_EXT_LOAD = 4'ha;
  localparam logic [3:0]  OP_EXT_STORE = 4'hb;
  localparam logic [3:0]  OP_CBZ = 4'hc;
  // fault kinds on the response port
  localparam logic [1:0]  FAULT_NONE = 2'h0;
  localparam logic [1:0]  FAULT_ISF = 2'h1;
  localparam logic [1:0]  FAULT_DSF = 2'h2;
  localparam logic [1:0]  FAULT_ALIGN = 2'h3;
endpackage

// >>> mmu_xlate_fault.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - no block match: locate segment descriptor
// - top four address bits pick segment
// - selector zero: form 52-bit virtual address
// - tlb hit: forward physical address
// - miss: walk table, fill, retry hits
// - protection violation raises storage fault
// - no entry anywhere: page fault bit 1
// - protection violation sets cause bit 4
// - fetch from no-execute segment: bit 3
// - fetch from direct-store segment: bit 3
// - data access to direct-store: bit 5
// - guarded fetch under translation: bit 3
// - data translation off: alignment faults only
// - zeroing to write-through/inhibited: alignment
// - reservation op to write-through: bit 5
// - reservation/external op to direct-store: bit 5
// - external op while disabled: bit 11
// - multiple/string under byte reversal: alignment
// - misaligned word operand under translation: alignment
// - save failing instruction address per fault
// - block match overrides page translation result
module mmu_xlate_fault import mmu_fault_pkg::*; #(
  parameter int TLB_ENTRIES = 4
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             reqValid,
  input  wire logic             reqFetch,
  input  wire logic [3:0]       reqOp,
  input  wire logic [31:0]      reqEa,
  input  wire logic [31:0]      reqInstrAddr,
  input  wire logic             blockHit,
  input  wire logic [31:0]      blockPa,
  input  wire logic             blockW,
  input  wire logic             blockI,
  input  wire logic             blockG,
  input  wire logic             blockViol,
  output logic                  reqReady,
  output logic                  rspValid,
  output logic [1:0]            rspFault,
  output logic [31:0]           rspPa,
  output logic                  walkReq,
  output logic [VPN_W-1:0]      walkVpn,
  input  wire logic             walkDone,
  input  wire logic             walkFound,
  input  wire logic [RPN_W-1:0] walkRpn,
  input  wire logic [4:0]       walkAttr
);
  localparam int IW = $clog2(TLB_ENTRIES);

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WALK} state_e;

  state_e           state;                    // access sequencer
  state_e           next_state;
  logic [31:0]      segReg [SEG_COUNT];       // segment descriptors
  logic [31:0]      ctrl;                     // machine state bits
  logic [31:0]      faultSave;                // fetch fault causes
  logic [31:0]      dataCause;                // data fault causes
  logic [31:0]      faultInstr;               // failing instruction address
  logic [31:0]      faultData;                // failing data address
  logic             rFetch;                   // captured request
  logic [3:0]       rOp;
  logic [31:0]      rEa;
  logic [31:0]      rIa;
  logic             rBlkHit;
  logic [31:0]      rBlkPa;
  logic             rBlkW;
  logic             rBlkI;
  logic             rBlkG;
  logic             rBlkViol;
  logic             pgMiss;                   // table walk came back empty
  logic             tlbValid [2][TLB_ENTRIES];
  logic [VPN_W-1:0] tlbVpn [2][TLB_ENTRIES];
  logic [RPN_W-1:0] tlbRpn [2][TLB_ENTRIES];
  logic [4:0]       tlbAttr [2][TLB_ENTRIES];
  logic [IW-1:0]    fillPtr [2];              // round-robin victims
  logic [TLB_ENTRIES-1:0] hitVec;
  logic [IW-1:0]    hitIdx;
  logic             tlbHit;
  logic [31:0]      seg;
  logic [VPN_W-1:0] vpn;
  logic             xlOn;
  logic             side;
  logic [1:0]       fk;                       // fault kind chosen
  logic [4:0]       cbit;                     // cause bit chosen
  logic             walkNeed;
  logic             apbWr;
  logic             mapped;
  logic [31:0]      rdMux;

  // ---------------- apb slave ----------------
  assign mapped = (paddr <= ADDR_STAT) && (paddr[1:0] == 2'h0);
  assign apbWr  = psel && penable && pready && pwrite && mapped;

  // read mux; unmapped reads return zero, except misaligned offsets below ADDR_CTRL, which return a segment descriptor
  always_comb begin
    rdMux = 32'h0;
    if (paddr < ADDR_CTRL) rdMux = segReg[paddr[5:2]];
    else if (paddr == ADDR_CTRL) rdMux = ctrl;
    else if (paddr == ADDR_FSS) rdMux = faultSave;
    else if (paddr == ADDR_DFC) rdMux = dataCause;
    else if (paddr == ADDR_FIA) rdMux = faultInstr;
    else if (paddr == ADDR_DFA) rdMux = faultData;
    else if (paddr == ADDR_STAT) rdMux = {29'h0, pgMiss, state != ST_IDLE, walkReq};
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rdMux;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // segment descriptor file
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < SEG_COUNT; k++) segReg[k] <= 32'h0;
    end else if (apbWr && paddr < ADDR_CTRL) begin
      segReg[paddr[5:2]] <= pwdata;
    end
  end

  // control; flush bit is a self-clearing strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (apbWr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata & 32'h1f;
    end
  end

  // ---------------- translation ----------------
  // segment select
  assign seg  = segReg[rEa[31:28]];
  // virtual page number of the 52-bit address
  assign vpn  = {seg[VSID_W-1:0], rEa[27:12]};
  assign xlOn = rFetch ? ctrl[CTL_FETCH_XLATE] : ctrl[CTL_DATA_XLATE];
  assign side = rFetch;

  // parallel compare against the relevant tlb
  for (genvar g = 0; g < TLB_ENTRIES; g++) begin : g_hit
    assign hitVec[g] = tlbValid[side][g] && (tlbVpn[side][g] == vpn);
  end

  // hit encoder; fill keeps entries unique so at most one hits
  always_comb begin
    hitIdx = '0;
    for (int k = 0; k < TLB_ENTRIES; k++) begin
      if (hitVec[k]) hitIdx = IW'(k);
    end
  end
  assign tlbHit = |hitVec;

  // classifier: exactly one outcome per access
  always_comb begin
    logic       store;
    logic       multi;
    logic       wordOp;
    logic       resv;
    logic       ext;
    logic       key;
    logic [4:0] at;
    logic       wt;
    logic       ci;
    logic       prot;
    // a fetch is a read whatever sits on the op lines
    store  = !rFetch && rOp[0] && rOp != OP_CBZ;
    multi  = rOp >= OP_MULTI_LOAD && rOp <= OP_STRING_STORE;
    resv   = rOp == OP_RESV_LOAD || rOp == OP_COND_STORE;
    ext    = rOp == OP_EXT_LOAD || rOp == OP_EXT_STORE;
    wordOp = rOp == OP_FP_LOAD || rOp == OP_FP_STORE || multi && !rOp[1] || resv || ext;
    key    = ctrl[CTL_PROBLEM] ? seg[SEG_KP_BIT] : seg[SEG_KS_BIT];
    at     = tlbAttr[side][hitIdx];
    // block attributes win over the page entry
    wt     = rBlkHit ? rBlkW : at[ATTR_W];
    ci     = rBlkHit ? rBlkI : at[ATTR_I];
    prot   = rBlkHit ? rBlkViol
           : (key ? (at[1:0] == 2'h0 || (store && at[1:0] != 2'h2)) : (store && at[1:0] == 2'h3));
    fk       = FAULT_NONE;
    cbit     = 5'd0;
    walkNeed = 1'b0;
    if (rFetch) begin
      if (!xlOn) begin
        fk = FAULT_NONE;
      end else if (rBlkHit && rBlkG) begin
        fk = FAULT_ISF; cbit = 5'(CAUSE_NOEXEC);
      end else if (!rBlkHit && (seg[SEG_T_BIT] || seg[SEG_N_BIT])) begin
        fk = FAULT_ISF; cbit = 5'(CAUSE_NOEXEC);
      end else if (!rBlkHit && pgMiss) begin
        fk = FAULT_ISF; cbit = 5'(CAUSE_PAGE);
      end else if (!rBlkHit && !tlbHit) begin
        walkNeed = 1'b1;
      end else if (!rBlkHit && at[ATTR_G]) begin
        fk = FAULT_ISF; cbit = 5'(CAUSE_NOEXEC);
      end else if (prot) begin
        fk = FAULT_ISF; cbit = 5'(CAUSE_PROT);
      end
    end else begin
      if (multi && ctrl[CTL_BYTE_REV]) begin
        fk = FAULT_ALIGN;
      end else if (!xlOn) begin
        fk = FAULT_NONE;
      end else if (ext && !ctrl[CTL_EXT_EN]) begin
        fk = FAULT_DSF; cbit = 5'(CAUSE_EXTDIS);
      end else if (wordOp && rEa[1:0] != 2'h0) begin
        fk = FAULT_ALIGN;
      end else if (!rBlkHit && seg[SEG_T_BIT]) begin
        fk = FAULT_DSF; cbit = 5'(CAUSE_DSTORE);
      end else if (!rBlkHit && pgMiss) begin
        fk = FAULT_DSF; cbit = 5'(CAUSE_PAGE);
      end else if (!rBlkHit && !tlbHit) begin
        walkNeed = 1'b1;
      end else if (rOp == OP_CBZ && (wt || ci)) begin
        fk = FAULT_ALIGN;
      end else if (resv && wt) begin
        fk = FAULT_DSF; cbit = 5'(CAUSE_DSTORE);
      end else if (prot) begin
        fk = FAULT_DSF; cbit = 5'(CAUSE_PROT);
      end
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (reqValid) next_state = ST_CHECK;
      ST_CHECK: next_state = walkNeed ? ST_WALK : ST_IDLE;
      ST_WALK:  if (walkDone) next_state = ST_CHECK;
      default:  next_state = ST_IDLE;
    endcase
  end

  // state register and ready flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      reqReady <= 1'b0;
    end else begin
      state    <= next_state;
      reqReady <= next_state == ST_IDLE;
    end
  end

  // request capture; block inputs are sampled with the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {rFetch, rOp, rEa, rIa} <= '0;
      {rBlkHit, rBlkPa, rBlkW, rBlkI, rBlkG, rBlkViol} <= '0;
    end else if (state == ST_IDLE && reqValid) begin
      {rFetch, rOp, rEa, rIa} <= {reqFetch, reqOp, reqEa, reqInstrAddr};
      {rBlkHit, rBlkPa, rBlkW, rBlkI, rBlkG, rBlkViol} <= {blockHit, blockPa, blockW, blockI, blockG, blockViol};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      walkReq <= 1'b0;
      walkVpn <= '0;
      pgMiss  <= 1'b0;
    end else begin
      if (state == ST_IDLE) pgMiss <= 1'b0;
      if (state == ST_CHECK && walkNeed) begin
        walkReq <= 1'b1;
        walkVpn <= vpn;
      end else if (state == ST_WALK && walkDone) begin
        walkReq <= 1'b0;
        pgMiss  <= !walkFound;
      end
    end
  end

  // fill on a found entry so the retry hits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < 2; s++) begin
        fillPtr[s] <= '0;
        for (int k = 0; k < TLB_ENTRIES; k++) begin
          tlbValid[s][k] <= 1'b0;
          tlbVpn[s][k]   <= '0;
          tlbRpn[s][k]   <= '0;
          tlbAttr[s][k]  <= '0;
        end
      end
    end else if (apbWr && paddr == ADDR_CTRL && pwdata[CTL_FLUSH]) begin
      // software must flush after rewriting descriptors or tables
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < TLB_ENTRIES; k++) tlbValid[s][k] <= 1'b0;
      end
    end else if (state == ST_WALK && walkDone && walkFound) begin
      tlbValid[side][fillPtr[side]] <= 1'b1;
      tlbVpn[side][fillPtr[side]]   <= walkVpn;
      tlbRpn[side][fillPtr[side]]   <= walkRpn;
      tlbAttr[side][fillPtr[side]]  <= walkAttr;
      fillPtr[side]                 <= fillPtr[side] + 1'b1;
    end
  end

  // response; address source: block, page or real
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspFault <= FAULT_NONE;
      rspPa    <= 32'h0;
    end else begin
      rspValid <= state == ST_CHECK && !walkNeed;
      if (state == ST_CHECK && !walkNeed) begin
        rspFault <= fk;
        rspPa    <= !xlOn ? rEa : rBlkHit ? rBlkPa : {tlbRpn[side][hitIdx], rEa[11:0]};
      end
    end
  end

  // fault records; a hardware fault beats a same-cycle software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {faultSave, dataCause, faultInstr, faultData} <= '0;
    end else begin
      if (apbWr && paddr == ADDR_FSS) faultSave <= pwdata;
      if (apbWr && paddr == ADDR_DFC) dataCause <= pwdata;
      if (apbWr && paddr == ADDR_FIA) faultInstr <= pwdata;
      if (apbWr && paddr == ADDR_DFA) faultData <= pwdata;
      if (state == ST_CHECK && !walkNeed && fk != FAULT_NONE) begin
        faultInstr <= rIa;
        if (!rFetch) faultData <= rEa;
        if (fk == FAULT_ISF) faultSave <= 32'h1 << cbit;
        if (fk == FAULT_DSF) dataCause <= 32'h1 << cbit;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  walk_issue_a: assert property (state == ST_CHECK && walkNeed |=> walkReq && walkVpn == $past(vpn))
    else $error("miss did not start a walk");
  retry_hit_a: assert property (state == ST_WALK && walkDone && walkFound |=> state == ST_CHECK && tlbHit)
    else $error("retry after fill missed");
  real_mode_a: assert property (rspValid && !$past(rFetch) && !$past(ctrl[CTL_DATA_XLATE])
    |-> rspFault != FAULT_DSF)
    else $error("storage fault with data translation off");
  byte_rev_a: assert property (state == ST_CHECK && !rFetch && rOp >= OP_MULTI_LOAD
    && rOp <= OP_STRING_STORE && ctrl[CTL_BYTE_REV] |=> rspValid && rspFault == FAULT_ALIGN)
    else $error("multiple under byte reversal not aligned-faulted");
  ext_dis_a: assert property (state == ST_CHECK && fk == FAULT_DSF && cbit == 5'(CAUSE_EXTDIS)
    |=> dataCause[CAUSE_EXTDIS] && rspFault == FAULT_DSF)
    else $error("external disable cause missing");
  page_fault_a: assert property (state == ST_CHECK && pgMiss && !rBlkHit && xlOn && fk != FAULT_ALIGN
    |=> rspValid ##0 (rspFault == FAULT_ALIGN || (rFetch ? faultSave : dataCause) != 32'h0))
    else $error("page fault not recorded");
  instr_addr_a: assert property (rspValid && rspFault != FAULT_NONE |-> faultInstr == $past(rIa))
    else $error("failing instruction address not saved");
  block_pa_a: assert property (state == ST_CHECK && !walkNeed && xlOn && rBlkHit
    |=> rspPa == rBlkPa)
    else $error("block address not used");
  one_cause_a: assert property (rspValid && rspFault == FAULT_DSF |-> $onehot(dataCause))
    else $error("more than one data cause bit");
  noexec_a: assert property (state == ST_CHECK && rFetch && xlOn && !rBlkHit && seg[SEG_N_BIT]
    |=> rspFault == FAULT_ISF && faultSave[CAUSE_NOEXEC])
    else $error("no-execute fetch not faulted");

  walk_found_c: cover property (state == ST_WALK && walkDone && walkFound ##1 state == ST_CHECK ##1 rspValid);
  page_miss_c:  cover property (state == ST_WALK && walkDone && !walkFound);
  block_ok_c:   cover property (rspValid && rspFault == FAULT_NONE && $past(rBlkHit));
  align_c:      cover property (rspValid && rspFault == FAULT_ALIGN);
endmodule
`default_nettype wire

// >>> walk_responder.sv
`timescale 1ns/1ps
`default_nettype none
// memory side of the table walk port: answers each walk once
module walk_responder import mmu_fault_pkg::*; (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             walkReq,
  input  wire logic             cfgFound,
  input  wire logic             cfgSlow,
  input  wire logic [RPN_W-1:0] cfgRpn,
  input  wire logic [4:0]       cfgAttr,
  output logic                  walkDone,
  output logic                  walkFound,
  output logic [RPN_W-1:0]      walkRpn,
  output logic [4:0]            walkAttr
);
  logic [3:0] waitCnt;  // cycles left before done
  logic       served;   // done given, wait for the request to drop
  // count down after the request, then pulse done once per request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 4'h0;
      served <= 1'b0;
      walkDone <= 1'b0;
    end else begin
      walkDone <= 1'b0;
      if (!walkReq) begin
        // slow mode stretches the search to exercise the wait path
        waitCnt <= cfgSlow ? 4'h6 : 4'h0;
        served <= 1'b0;
      end else if (!served && waitCnt == 4'h0) begin
        walkDone <= 1'b1;
        served <= 1'b1;
      end else if (!served) begin
        waitCnt <= waitCnt - 4'h1;
      end
    end
  end
  // result lines carry junk outside the done cycle so stale values never match
  assign walkFound = walkDone ? cfgFound : ~cfgFound;
  assign walkRpn   = walkDone ? cfgRpn : ~cfgRpn;
  assign walkAttr  = walkDone ? cfgAttr : ~cfgAttr;
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import mmu_fault_pkg::*;;
  logic             clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, reqEa, reqInstrAddr, blockPa, rspPa;
  logic             reqValid, reqFetch, blockHit, blockW, blockI, blockG, blockViol;
  logic             reqReady, rspValid, walkReq, walkDone, walkFound;
  logic [3:0]       reqOp;
  logic [1:0]       rspFault;
  logic [VPN_W-1:0] walkVpn, lastVpn;
  logic [RPN_W-1:0] walkRpn, cfgRpn;
  logic [4:0]       walkAttr, cfgAttr;
  logic             cfgFound, cfgSlow, sawWalk;
  int               nMismatch, comparisons;

  mmu_xlate_fault #(.TLB_ENTRIES(4)) dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .reqValid, .reqFetch, .reqOp, .reqEa, .reqInstrAddr, .blockHit,
    .blockPa, .blockW, .blockI, .blockG, .blockViol, .reqReady, .rspValid, .rspFault, .rspPa,
    .walkReq, .walkVpn, .walkDone, .walkFound, .walkRpn, .walkAttr);
  walk_responder mem (.clk, .reset_n, .walkReq, .cfgFound, .cfgSlow, .cfgRpn, .cfgAttr,
    .walkDone, .walkFound, .walkRpn, .walkAttr);

  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // keep the last walk key for later comparison
  always @(posedge clk) begin
    if (walkReq) lastVpn <= walkVpn;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) nMismatch++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, expErr});
  endtask
  // one core access; fault records are read back when a storage fault is expected
  task automatic acc(input logic f, input logic [3:0] op, input logic [31:0] ea,
                     input logic [1:0] ef, input logic [31:0] epa, input logic [31:0] cause);
    int n;
    n = 0;
    sawWalk = 1'b0;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqFetch <= f;
    reqOp <= op;
    reqEa <= ea;
    reqInstrAddr <= ~ea;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    reqEa <= ~ea;
    do begin
      @(posedge clk);
      n++;
      sawWalk |= walkReq;
    end while (rspValid !== 1'b1 && n < 100);
    if (rspValid !== 1'b1) nMismatch++;
    chk({30'h0, rspFault}, {30'h0, ef});
    if (ef == FAULT_NONE) chk(rspPa, epa);
    if (ef == FAULT_ISF) begin
      rd(ADDR_FSS, cause, 1'b0);
      rd(ADDR_FIA, ~ea, 1'b0);
    end
    if (ef == FAULT_DSF) begin
      rd(ADDR_DFC, cause, 1'b0);
      rd(ADDR_FIA, ~ea, 1'b0);
    end
  endtask

  // register defaults, unmapped refusal, segment setup
  task automatic t_regs;
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(8'h58, 32'h0, 1'b1);
    wr(ADDR_SEG0, 32'h0012_3456);
    wr(ADDR_SEG0 + 8'h04, 32'h8000_0000);
    wr(ADDR_SEG0 + 8'h08, 32'h1012_3456);
    rd(ADDR_SEG0 + 8'h08, 32'h1012_3456, 1'b0);
    $display("registers done");
  endtask
  // translation off: only alignment faults survive
  task automatic t_real;
    wr(ADDR_CTRL, 32'h4);
    acc(1'b0, OP_MULTI_LOAD, 32'h0000_2000, FAULT_ALIGN, 32'h0, 32'h0);
    acc(1'b0, OP_EXT_LOAD, 32'h1000_0002, FAULT_NONE, 32'h1000_0002, 32'h0);
    acc(1'b1, OP_LOAD, 32'h2000_0040, FAULT_NONE, 32'h2000_0040, 32'h0);
    $display("real mode done");
  endtask
  // miss walks the table, refill then hits without a walk
  task automatic t_page;
    wr(ADDR_CTRL, 32'h3);
    cfgFound <= 1'b1;
    cfgRpn <= 20'habcde;
    cfgAttr <= 5'h02;
    acc(1'b0, OP_LOAD, 32'h0000_1004, FAULT_NONE, 32'habcd_e004, 32'h0);
    chk({31'h0, sawWalk}, 32'h1);
    chk({31'h0, lastVpn === 40'h12_3456_0001}, 32'h1);
    acc(1'b0, OP_LOAD, 32'h0000_1ff8, FAULT_NONE, 32'habcd_eff8, 32'h0);
    chk({31'h0, sawWalk}, 32'h0);
    acc(1'b0, OP_FP_LOAD, 32'h0000_1002, FAULT_ALIGN, 32'h0, 32'h0);
    $display("page translation done");
  endtask
  // slow walk that finds nothing
  task automatic t_pfault;
    cfgFound <= 1'b0;
    cfgSlow <= 1'b1;
    acc(1'b0, OP_STORE, 32'h0000_5000, FAULT_DSF, 32'h0, 32'h4000_0000);
    acc(1'b1, OP_LOAD, 32'h0000_6000, FAULT_ISF, 32'h0, 32'h4000_0000);
    cfgSlow <= 1'b0;
    cfgFound <= 1'b1;
    $display("page fault done");
  endtask
  // segment kinds and external control checks
  task automatic t_seg;
    acc(1'b0, OP_FP_STORE, 32'h1000_0000, FAULT_DSF, 32'h0, 32'h0400_0000);
    acc(1'b1, OP_LOAD, 32'h1000_0100, FAULT_ISF, 32'h0, 32'h1000_0000);
    acc(1'b1, OP_LOAD, 32'h2000_0100, FAULT_ISF, 32'h0, 32'h1000_0000);
    acc(1'b0, OP_EXT_LOAD, 32'h0000_1008, FAULT_DSF, 32'h0, 32'h0010_0000);
    wr(ADDR_CTRL, 32'h13);
    acc(1'b0, OP_EXT_STORE, 32'h1000_0008, FAULT_DSF, 32'h0, 32'h0400_0000);
    acc(1'b0, OP_COND_STORE, 32'h1000_000c, FAULT_DSF, 32'h0, 32'h0400_0000);
    wr(ADDR_CTRL, 32'h7);
    acc(1'b0, OP_STRING_LOAD, 32'h0000_1010, FAULT_ALIGN, 32'h0, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    $display("segment checks done");
  endtask
  // page attributes: protection, guard, write-through, inhibit
  task automatic t_attr;
    cfgAttr <= 5'h03;
    acc(1'b0, OP_STORE, 32'h0000_7000, FAULT_DSF, 32'h0, 32'h0800_0000);
    acc(1'b1, OP_STORE, 32'h0000_7000, FAULT_NONE, 32'habcd_e000, 32'h0);
    cfgAttr <= 5'h06;
    acc(1'b1, OP_LOAD, 32'h0000_8000, FAULT_ISF, 32'h0, 32'h1000_0000);
    cfgAttr <= 5'h12;
    acc(1'b0, OP_RESV_LOAD, 32'h0000_9000, FAULT_DSF, 32'h0, 32'h0400_0000);
    cfgAttr <= 5'h0a;
    acc(1'b0, OP_CBZ, 32'h0000_a000, FAULT_ALIGN, 32'h0, 32'h0);
    $display("page attributes done");
  endtask
  // block match overrides the segment path
  task automatic t_block;
    blockHit <= 1'b1;
    blockPa <= 32'hfedc_b010;
    acc(1'b0, OP_LOAD, 32'h1000_0010, FAULT_NONE, 32'hfedc_b010, 32'h0);
    blockG <= 1'b1;
    acc(1'b1, OP_LOAD, 32'h0000_0040, FAULT_ISF, 32'h0, 32'h1000_0000);
    blockG <= 1'b0;
    blockViol <= 1'b1;
    acc(1'b1, OP_LOAD, 32'h0000_0080, FAULT_ISF, 32'h0, 32'h0800_0000);
    acc(1'b0, OP_LOAD, 32'h1000_0020, FAULT_DSF, 32'h0, 32'h0800_0000);
    blockViol <= 1'b0;
    blockHit <= 1'b0;
    $display("block override done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {reset_n, psel, penable, pwrite, reqValid, reqFetch, blockHit, blockW, blockI} = '0;
    {blockG, blockViol, cfgFound, cfgSlow} = '0;
    {paddr, pwdata, reqOp, reqEa, reqInstrAddr, blockPa, cfgRpn, cfgAttr} = '0;
    nMismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_real();
    t_page();
    t_pfault();
    t_seg();
    t_attr();
    t_block();
    wrap_up();
  end
  // watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    nMismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
